// *** inc/emsg_pkg.sv ***
// Constants, types and the state record of the external memory strobe generator.
// Assumes one 200 MHz clock; one tick of the clock enable is one half clock period.
//
// ****************************************************************
// Behaviour
// [R1] Read strobe is low through T4, wait and T5 of a read, high otherwise.
// [R2] Read data is taken at the rising edge of the read strobe.
// [R3] Read strobe low time grows with T4 and T5 extras and waits.
// [R4] Five general strobes: one fixed, four with configured timing.
// [R5] Fixed strobe falls at start of T2 and rises at end of T5.
// [R6] Width strobe falls at start of T2, low for 0 to 31 half periods.
// [R7] Width strobe is high again no later than the end of T6.
// [R8] Waits do not stretch the width strobe; its count runs from T2.
// [R9] Width strobe configured to zero stays high all cycle.
// [R10] Three delayed strobes fall 1 to 31 half periods after T2, rise at T5 end.
// [R11] A delay reaching past T5 keeps the strobe high unless waits lengthen it.
// [R12] A delayed strobe configured to zero stays high all cycle.
// [R13] Four active-low byte write strobes; index 0 is the low byte.
// [R14] Byte lanes not written are not driven during a write.
// [R15] Late write strobes low in T4 and T5; early ones also in T3.
// [R16] Memory latches write data on write strobe rise; data held to T6 end.
// [R17] Write strobe low time grows with extras in T3 to T5 and waits.
// [R18] Extra half periods in T6 lengthen write data hold.
// [R19] T1 to T5 last 1 to 4 half periods, T6 1 to 5, waits any number.
// [R20] A cycle runs T1, T2, T3, T4, wait, T5, T6 in order.
// [R21] Byte write strobes stay high for internal-only accesses.
// [R22] One half clock period is exactly half a processor clock output period.
// [R23] T1 starts on a rising clock output edge; odd totals add one period (the code adds one half period, PH_E, when T1 to T6 sum to an even count).
// [R24] After reset every phase lasts four half periods.
// [R25] T4 may be extended without limit by external wait requests.
// [R26] Wait request sampled at T4 end and each wait period.
// ****************************************************************
package emsg_pkg;

   typedef enum logic [3:0] {
      PH_IDLE, PH_T1, PH_T2, PH_T3, PH_T4, PH_WAIT, PH_T5, PH_T6, PH_E
   } emsg_phase_t;

   // Register byte addresses.
   localparam logic [11:0] OFS_PHASE_CFG  = 12'h000;
   localparam logic [11:0] OFS_STROBE_CFG = 12'h004;
   localparam logic [11:0] OFS_STATUS     = 12'h008;
   localparam logic [11:0] OFS_RDATA      = 12'h00c;

   // Phase extras: two bits for T1..T5, three for T6.
   localparam int          PX_W       = 2;
   localparam int          T6X_LSB    = 10;
   localparam int          T6X_W      = 3;
   localparam logic [2:0]  T6X_MAX    = 3'h4;
   localparam int          PCFG_W     = 13;
   localparam logic [12:0] PCFG_RST   = 13'h0fff;

   // Strobe fields: width, three delays, late-write bit.
   localparam int          SF_W       = 5;
   localparam int          S1_LSB     = 0;
   localparam int          D_LSB      = 5;
   localparam int          LATE_BIT   = 20;
   localparam int          SCFG_W     = 21;
   localparam logic [20:0] SCFG_RST   = {1'b1, 5'h12, 5'h1e, 5'h1e, 5'h1f};

   localparam int          NDLY       = 3;
   localparam logic [5:0]  SCNT_MAX   = 6'h3f;
   localparam logic [2:0]  CNT_ONE    = 3'h1;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        internal;
      logic [29:0] addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } emsg_req_t;

   typedef struct packed {
      logic                pco;
      emsg_phase_t         ph;
      logic [2:0]          cnt;
      logic [5:0]          scnt;
      logic                wr;
      logic [3:0]          be;
      logic [29:0]         addr;
      logic [31:0]         wdata;
      logic [PCFG_W-1:0]   pcfg;
      logic [SCFG_W-1:0]   scfg;
      logic                rs_n;
      logic                s0_n;
      logic                s1_n;
      logic [NDLY-1:0]     ds_n;
      logic [3:0]          wb_n;
      logic [31:0]         ad_o;
      logic [3:0]          ad_oe;
      logic                cap;
      logic [31:0]         rdata;
      logic                done;
      logic                ready;
      logic                wt_s1;
      logic                wt_s2;
      logic [31:0]         ad_s1;
      logic [31:0]         ad_s2;
      logic                pready;
      logic                pslverr;
      logic [31:0]         prdata;
   } emsg_state_t;

   localparam emsg_state_t ST_RST = '{
      pco: 1'b0, ph: PH_IDLE, cnt: 3'h0, scnt: 6'h00, wr: 1'b0, be: 4'h0,
      addr: 30'h0, wdata: 32'h0, pcfg: PCFG_RST, scfg: SCFG_RST,
      rs_n: 1'b1, s0_n: 1'b1, s1_n: 1'b1, ds_n: 3'h7, wb_n: 4'hf,
      ad_o: 32'h0, ad_oe: 4'h0, cap: 1'b0, rdata: 32'h0, done: 1'b0,
      ready: 1'b0, wt_s1: 1'b0, wt_s2: 1'b0, ad_s1: 32'h0, ad_s2: 32'h0,
      pready: 1'b0, pslverr: 1'b0, prdata: 32'h0};

endpackage : emsg_pkg

// *** logic/emsg_strobe_gen.sv ***
// External memory cycle sequencer and strobe generator with an APB register slave.
// Assumes the pins are joined to the bus by the bench from ad_o and its byte enables.
`timescale 1ns/1ps
`default_nettype none

module emsg_strobe_gen (
   input  wire logic                sys_clk,
   input  wire logic                rstn,
   input  wire logic                ce,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire emsg_pkg::emsg_req_t req,
   output logic                     req_ready,
   output logic                     req_done,
   output logic      [31:0]         req_rdata,
   output logic                     processor_clock_output,
   output logic                     read_strobe_n,
   output logic                     fixed_format_strobe_n,
   output logic                     width_config_strobe_n,
   output logic      [2:0]          delayed_strobes_n,
   output logic      [3:0]          byte_write_strobes_n,
   output logic      [31:0]         mem_ad_o,
   output logic      [3:0]          mem_ad_oe,
   input  wire logic [31:0]         mem_ad_i,
   input  wire logic                wait_req
);
   import emsg_pkg::*;

   emsg_state_t r_reg;
   emsg_state_t r_next;

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Length minus one of a phase, from its configured extra half periods.
   function automatic logic [2:0] plen_m1(input emsg_phase_t ph, input logic [PCFG_W-1:0] c);
      logic [2:0] x;
      x = 3'h0;
      case (ph)
         PH_T1:   x = {1'b0, c[0*PX_W +: PX_W]};
         PH_T2:   x = {1'b0, c[1*PX_W +: PX_W]};
         PH_T3:   x = {1'b0, c[2*PX_W +: PX_W]};
         PH_T4:   x = {1'b0, c[3*PX_W +: PX_W]};
         PH_T5:   x = {1'b0, c[4*PX_W +: PX_W]};
         PH_T6: begin
            x = c[T6X_LSB +: T6X_W];
            if (x > T6X_MAX) begin
               x = T6X_MAX;
            end
         end
         default: x = 3'h0;
      endcase
      return x;
   endfunction : plen_m1

   // Phases from T2 to T5, including the wait period.
   function automatic logic in_t2_t5(input emsg_phase_t ph);
      return (ph == PH_T2) || (ph == PH_T3) || (ph == PH_T4) ||
             (ph == PH_WAIT) || (ph == PH_T5);
   endfunction : in_t2_t5

   // ****************************************************************
   // Next state
   // ****************************************************************

   always_comb begin
      logic          adv;
      emsg_phase_t   nph;
      logic [4:0]    w;
      logic [4:0]    d;
      logic          mapped;
      logic [31:0]   rd;
      adv    = 1'b0;
      nph    = PH_IDLE;
      w      = 5'h0;
      d      = 5'h0;
      mapped = 1'b0;
      rd     = 32'h0;
      r_next = r_reg;
      if (ce) begin
         r_next.pco   = ~r_reg.pco;                          // [R22]
         r_next.wt_s1 = wait_req;
         r_next.wt_s2 = r_reg.wt_s1;
         r_next.ad_s1 = mem_ad_i;
         r_next.ad_s2 = r_reg.ad_s1;
         r_next.done  = 1'b0;

         // Phase sequencer.
         case (r_reg.ph)
            PH_IDLE: begin
               if (r_reg.ready && req.valid) begin
                  r_next.wr    = req.write;
                  r_next.be    = req.be;
                  r_next.addr  = req.addr;
                  r_next.wdata = req.wdata;
                  if (req.internal) begin
                     r_next.done = 1'b1;                     // [R21]
                  end else begin
                     r_next.ph  = PH_T1;                     // [R23]
                     r_next.cnt = plen_m1(PH_T1, r_reg.pcfg);
                  end
               end
            end
            PH_T1, PH_T2, PH_T3, PH_T4, PH_T5, PH_T6: begin
               if (r_reg.cnt != 3'h0) begin
                  r_next.cnt = r_reg.cnt - CNT_ONE;          // [R19]
               end else begin
                  adv = 1'b1;
               end
            end
            PH_WAIT: begin
               if (!r_reg.wt_s2) begin
                  adv = 1'b1;
               end
            end
            PH_E: begin
               r_next.ph   = PH_IDLE;
               r_next.done = 1'b1;
            end
            default: r_next.ph = PH_IDLE;
         endcase

         if (adv) begin
            case (r_reg.ph)                                  // [R20]
               PH_T1:   nph = PH_T2;
               PH_T2:   nph = PH_T3;
               PH_T3:   nph = PH_T4;
               PH_T4:   nph = r_reg.wt_s2 ? PH_WAIT : PH_T5; // [R25] [R26]
               PH_WAIT: nph = PH_T5;
               PH_T5:   nph = PH_T6;
               PH_T6:   nph = r_next.pco ? PH_E : PH_IDLE;   // [R23]
               default: nph = PH_IDLE;
            endcase
            r_next.ph  = nph;
            r_next.cnt = plen_m1(nph, r_reg.pcfg);
            if (nph == PH_IDLE) begin
               r_next.done = 1'b1;
            end
         end

         // Half periods since the start of T2, running through waits.
         if ((r_reg.ph == PH_T1) && (r_next.ph == PH_T2)) begin
            r_next.scnt = 6'h00;
         end else if (r_reg.scnt != SCNT_MAX) begin
            r_next.scnt = r_reg.scnt + 6'h01;                // [R8]
         end

         // Strobes are registered from the next phase.
         r_next.s0_n = !in_t2_t5(r_next.ph);                 // [R5]
         w = r_reg.scfg[S1_LSB +: SF_W];
         r_next.s1_n = !((in_t2_t5(r_next.ph) || (r_next.ph == PH_T6)) &&   // [R7]
                         (w != 5'h0) &&                                     // [R9]
                         ({1'b0, r_next.scnt} < {2'b00, w}));               // [R6] [R8]
         for (int i = 0; i < NDLY; i++) begin                // [R4]
            d = r_reg.scfg[D_LSB + i*SF_W +: SF_W];
            r_next.ds_n[i] = !(in_t2_t5(r_next.ph) &&        // [R10] [R11]
                               (d != 5'h0) &&                // [R12]
                               ({1'b0, r_next.scnt} >= {2'b00, d}));
         end
         r_next.rs_n = !(!r_next.wr &&                       // [R1] [R3]
                         ((r_next.ph == PH_T4) || (r_next.ph == PH_WAIT) ||
                          (r_next.ph == PH_T5)));
         r_next.wb_n = 4'hf;
         if (r_next.wr && ((r_next.ph == PH_T4) || (r_next.ph == PH_WAIT) ||
                           (r_next.ph == PH_T5) ||
                           ((r_next.ph == PH_T3) && !r_reg.scfg[LATE_BIT]))) begin
            r_next.wb_n = ~r_next.be;                        // [R13] [R15] [R17]
         end

         // Multiplexed address and data bus.
         r_next.ad_o  = 32'h0;
         r_next.ad_oe = 4'h0;
         if ((r_next.ph == PH_T1) || (r_next.ph == PH_T2)) begin
            r_next.ad_o  = {r_next.addr, 1'b1, ~r_next.wr};
            r_next.ad_oe = 4'hf;
         end else if (r_next.wr && (r_next.ph != PH_IDLE)) begin
            r_next.ad_o  = r_next.wdata;                     // [R16] [R18]
            r_next.ad_oe = r_next.be;                        // [R14]
         end

         // Read data from the sample taken just before the strobe rose.
         r_next.cap = !r_reg.rs_n && r_next.rs_n;            // [R2]
         if (r_reg.cap) begin
            r_next.rdata = r_reg.ad_s2;                      // [R2]
         end
         r_next.ready = (r_next.ph == PH_IDLE) && !r_next.pco;   // [R23]

         // APB slave: answer in the access phase after each setup that falls on a clock enable tick.
         case (paddr)
            OFS_PHASE_CFG:  begin mapped = 1'b1; rd = 32'(r_reg.pcfg); end
            OFS_STROBE_CFG: begin mapped = 1'b1; rd = 32'(r_reg.scfg); end
            OFS_STATUS:     begin
               mapped = 1'b1;
               rd = {26'h0, r_reg.wt_s2, r_reg.ph, (r_reg.ph != PH_IDLE)};
            end
            OFS_RDATA:      begin mapped = 1'b1; rd = r_reg.rdata; end
            default:        begin mapped = 1'b0; rd = 32'h0; end
         endcase
         r_next.pready  = 1'b0;
         r_next.pslverr = 1'b0;
         if (psel && !penable) begin
            r_next.pready  = 1'b1;
            r_next.pslverr = !mapped;
            r_next.prdata  = pwrite ? 32'h0 : rd;
         end
         if (psel && penable && r_reg.pready && pwrite) begin
            if (paddr == OFS_PHASE_CFG) begin
               r_next.pcfg = pwdata[PCFG_W-1:0];             // [R24]
            end
            if (paddr == OFS_STROBE_CFG) begin
               r_next.scfg = pwdata[SCFG_W-1:0];
            end
         end
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         r_reg <= ST_RST;                                    // [R24]
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata                 = r_reg.prdata;
   assign pready                 = r_reg.pready;
   assign pslverr                = r_reg.pslverr;
   assign req_ready              = r_reg.ready;
   assign req_done               = r_reg.done;
   assign req_rdata              = r_reg.rdata;
   assign processor_clock_output = r_reg.pco;
   assign read_strobe_n          = r_reg.rs_n;
   assign fixed_format_strobe_n  = r_reg.s0_n;
   assign width_config_strobe_n  = r_reg.s1_n;
   assign delayed_strobes_n      = r_reg.ds_n;
   assign byte_write_strobes_n   = r_reg.wb_n;
   assign mem_ad_o               = r_reg.ad_o;
   assign mem_ad_oe              = r_reg.ad_oe;

endmodule : emsg_strobe_gen

`default_nettype wire

// *** sim/emsg_mem_model.sv ***
// Behavioural external memory on the multiplexed address and data bus.
// Assumes the bench resolves the bus from the lane enables of the design.
`timescale 1ns/1ps
`default_nettype none
// ***********************
// Memory model
// ***********************
module emsg_mem_model (
   input  wire logic        sys_clk,
   input  wire logic        fixed_format_strobe_n,
   input  wire logic        read_strobe_n,
   input  wire logic [3:0]  byte_write_strobes_n,
   input  wire logic [31:0] bus,
   input  wire logic        wt_en,
   output logic      [31:0] rd_bus,
   output logic             wait_req
);
   logic [31:0] mem [16];
   logic [3:0]  a = 4'h0;
   logic [3:0]  wb_q = 4'hf;
   int          wcnt = 0;
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = {4{8'(i)}} ^ 32'hc35a_a53c;
   end
   // The word address is taken as the main strobe falls.
   always @(negedge fixed_format_strobe_n) a = bus[5:2];
   // Data is driven at all times, inverted while the read strobe is high.
   assign rd_bus = read_strobe_n ? ~mem[a] : mem[a];
   // Each lane is latched on the rising edge of its strobe.
   always @(byte_write_strobes_n) begin
      for (int i = 0; i < 4; i++)
         if (byte_write_strobes_n[i] && !wb_q[i]) mem[a][8*i+:8] = bus[8*i+:8];
      wb_q = byte_write_strobes_n;
   end
   // Waits are asked for during sixteen clocks after the main strobe falls.
   always @(posedge sys_clk) wcnt <= fixed_format_strobe_n ? 0 : wcnt + 1;
   assign wait_req = wt_en && !fixed_format_strobe_n && wcnt < 16;
endmodule : emsg_mem_model
`default_nettype wire

// *** sim/emsg_strobe_gen_assertions.sv ***
// Concurrent checks on the pins of the strobe generator.
// Assumes it is bound to emsg_strobe_gen and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
// ***********************
// Checker
// ***********************
module emsg_strobe_gen_assertions (
   input wire logic       sys_clk,
   input wire logic       rstn,
   input wire logic       ce,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       req_done,
   input wire logic       processor_clock_output,
   input wire logic       read_strobe_n,
   input wire logic       fixed_format_strobe_n,
   input wire logic       width_config_strobe_n,
   input wire logic [2:0] delayed_strobes_n,
   input wire logic [3:0] byte_write_strobes_n,
   input wire logic [3:0] mem_ad_oe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_rd_inside: assert property (
      !read_strobe_n |-> !fixed_format_strobe_n && mem_ad_oe == 4'h0) else $error("read late");
   a_rd_s0_rise: assert property (
      $rose(read_strobe_n) |-> $rose(fixed_format_strobe_n)) else $error("read end");
   a_wb_s0_rise: assert property (
      $rose(&byte_write_strobes_n) |-> $rose(fixed_format_strobe_n)) else $error("write end");
   a_wb_lanes: assert property (
      byte_write_strobes_n != 4'hf |-> mem_ad_oe == ~byte_write_strobes_n) else $error("lanes");
   a_s1_start: assert property (
      $fell(width_config_strobe_n) |-> $fell(fixed_format_strobe_n)) else $error("width start");
   a_dly_inside: assert property (
      delayed_strobes_n != 3'h7 |-> !fixed_format_strobe_n) else $error("delayed strobe");
   a_rd_wr_excl: assert property (
      !read_strobe_n |-> byte_write_strobes_n == 4'hf) else $error("read and write");
   a_pco_tick: assert property (
      ce |=> processor_clock_output != $past(processor_clock_output)) else $error("clock out");
   a_done_idle: assert property (
      req_done |-> width_config_strobe_n && fixed_format_strobe_n && delayed_strobes_n == 3'h7)
      else $error("strobe past cycle");
   a_apb_answer: assert property (
      psel && !penable && ce |=> pready) else $error("apb late");
   c_read: cover property ($fell(read_strobe_n));
   c_write: cover property ($fell(byte_write_strobes_n[3]));
   c_delay: cover property ($fell(delayed_strobes_n[0]));
endmodule : emsg_strobe_gen_assertions

bind emsg_strobe_gen emsg_strobe_gen_assertions u_chk (
   .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
   .pready(pready), .req_done(req_done), .processor_clock_output(processor_clock_output),
   .read_strobe_n(read_strobe_n), .fixed_format_strobe_n(fixed_format_strobe_n),
   .width_config_strobe_n(width_config_strobe_n), .delayed_strobes_n(delayed_strobes_n),
   .byte_write_strobes_n(byte_write_strobes_n), .mem_ad_oe(mem_ad_oe));
`default_nettype wire

// *** sim/emsg_strobe_gen_tb.sv ***
// Self-checking bench for the strobe generator with a memory model.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
// ***********************
// Bench
// ***********************
module emsg_strobe_gen_tb;
   import emsg_pkg::*;
   typedef struct {int s0; int rd; int s1; int lim; int d[3]; int wb; logic [1:0] k;
                   logic [3:0] a; logic [3:0] be; logic [31:0] dat; logic wt;} emsg_exp_t;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        ce = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   emsg_req_t   req = '0;
   logic        wt_en = 1'b0;
   logic        ce_rand = 1'b0;
   logic [31:0] prdata, req_rdata, ad_o, ad_i, rd_bus, oe_m;
   logic        pready, pslverr, req_ready, req_done, pco, rd_n, s0_n, s1_n, wait_req;
   logic [2:0]  dly_n;
   logic [3:0]  wb_n, oe, wl;
   emsg_exp_t   mq[$];
   logic [32:0] aq[$];
   logic [31:0] shadow [16];
   int          t [6];
   int          sd [3];
   int          cd [3];
   int          sw, c0, cr, c1, cw, fails, num_checks;
   logic        late;
   emsg_strobe_gen dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .req(req), .req_ready(req_ready),
      .req_done(req_done), .req_rdata(req_rdata), .processor_clock_output(pco),
      .read_strobe_n(rd_n), .fixed_format_strobe_n(s0_n), .width_config_strobe_n(s1_n),
      .delayed_strobes_n(dly_n), .byte_write_strobes_n(wb_n), .mem_ad_o(ad_o),
      .mem_ad_oe(oe), .mem_ad_i(ad_i), .wait_req(wait_req));
   emsg_mem_model u_mem (.sys_clk(sys_clk), .fixed_format_strobe_n(s0_n),
      .read_strobe_n(rd_n), .byte_write_strobes_n(wb_n), .bus(ad_i), .wt_en(wt_en),
      .rd_bus(rd_bus), .wait_req(wait_req));
   assign oe_m = {{8{oe[3]}}, {8{oe[2]}}, {8{oe[1]}}, {8{oe[0]}}};
   assign ad_i = (ad_o & oe_m) | (rd_bus & ~oe_m);
   initial forever #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) ce <= ce_rand ? ($urandom % 4 != 0) : 1'b1;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] x);
      int n;
      n = 0;
      @(posedge sys_clk);
      if (!w) aq.push_back(x);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 200);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 200) fails++;
   endtask : apb
   task automatic mem_op(input logic [1:0] k, input logic [3:0] a, input logic [3:0] be,
                         input logic [31:0] d);
      emsg_exp_t e;
      int n;
      n = 0;
      e.k = k; e.a = a; e.be = be; e.wt = wt_en && k != 0; e.s1 = sw; e.d = sd;
      e.s0 = k != 0 ? t[1] + t[2] + t[3] + t[4] : 0;
      e.lim = k != 0 ? e.s0 + t[5] : 0;
      e.rd = k == 1 ? t[3] + t[4] : 0;
      e.wb = k == 2 ? t[3] + t[4] + (late ? 0 : t[2]) : 0;
      if (k == 2) for (int i = 0; i < 4; i++) if (be[i]) shadow[a][8*i+:8] = d[8*i+:8];
      e.dat = k == 2 ? d : shadow[a];
      mq.push_back(e);
      req <= '{valid: 1'b1, write: k == 2 || (k == 0 && a[0]), internal: k == 0,
               addr: {26'h0, a}, be: be,
               wdata: d};
      do @(posedge sys_clk); while (!(req_ready === 1'b1 && ce === 1'b1) && ++n < 2000);
      if (n >= 2000) fails++;
   endtask : mem_op
   task automatic drain;
      int n;
      n = 0;
      req.valid <= 1'b0;
      while (mq.size() != 0 && n++ < 5000) @(posedge sys_clk);
      if (mq.size() != 0) chk(32'(mq.size()), 32'h0);
   endtask : drain
   always @(posedge sys_clk) begin
      emsg_exp_t e;
      int w;
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         chk({31'h0, pslverr}, {31'h0, aq[0][32]});
         chk(prdata, aq[0][31:0]);
         void'(aq.pop_front());
      end
      if (rstn && ce === 1'b1) begin
         c0 += !s0_n; cr += !rd_n; c1 += !s1_n; cw += (wb_n != 4'hf);
         if (wb_n != 4'hf) wl = ~wb_n;
         for (int i = 0; i < 3; i++) cd[i] += !dly_n[i];
         if (req_done === 1'b1 && mq.size() == 0) chk(32'h1, 32'h0);
         if (req_done === 1'b1 && mq.size() != 0) begin
            e = mq.pop_front();
            w = c0 - e.s0;
            chk(e.wt ? 32'(w > 0) : w, 32'(e.wt));
            chk(cr, e.rd != 0 ? e.rd + w : 0);
            chk(cw, e.wb != 0 ? e.wb + w : 0);
            chk(c1, e.s1 < e.lim + w ? e.s1 : e.lim + w);
            for (int i = 0; i < 3; i++)
               chk(cd[i], (e.d[i] == 0 || e.d[i] >= e.s0 + w) ? 0 : e.s0 + w - e.d[i]);
            if (e.k == 1) chk(req_rdata, e.dat);
            if (e.k == 2) chk({28'h0, wl}, {28'h0, e.be});
            if (e.k == 2) chk(u_mem.mem[e.a] & oe_of(e.be), e.dat & oe_of(e.be));
            c0 = 0; cr = 0; c1 = 0; cw = 0; cd = '{0, 0, 0};
         end
      end
   end
   function automatic logic [31:0] oe_of(input logic [3:0] b);
      return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
   endfunction : oe_of
   initial begin
      #(5 * 60000);
      fails++;
      wrap_up;
   end
   initial begin
      logic [31:0] p, s;
      void'($urandom(66));
      for (int i = 0; i < 16; i++) shadow[i] = {4{8'(i)}} ^ 32'hc35a_a53c;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      apb(1'b0, OFS_PHASE_CFG, 32'h0, {1'b0, 19'h0, PCFG_RST});
      apb(1'b0, OFS_STROBE_CFG, 32'h0, {1'b0, 11'h0, SCFG_RST});
      apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
      t = '{4, 4, 4, 4, 4, 4}; sw = SCFG_RST[4:0]; late = SCFG_RST[LATE_BIT];
      for (int j = 0; j < 3; j++) sd[j] = SCFG_RST[D_LSB + 5 * j +: 5];
      mem_op(2'd1, 4'h3, 4'hf, 32'h0);
      mem_op(2'd2, 4'h3, 4'h5, 32'h1234_5678);
      mem_op(2'd1, 4'h3, 4'hf, 32'h0);
      drain;
      apb(1'b0, OFS_STATUS, 32'h0, 33'h0);
      $display("test 0 done");
      for (int i = 1; i <= 12; i++) begin
         for (int j = 0; j < 6; j++) t[j] = 1 + $urandom % (j == 5 ? 5 : 4);
         sw = i == 1 ? 0 : $urandom % 32;
         for (int j = 0; j < 3; j++) sd[j] = i == 1 ? j : $urandom % 32;
         late = 1'($urandom);
         p = {19'h0, 3'(t[5] - 1), 2'(t[4] - 1), 2'(t[3] - 1), 2'(t[2] - 1), 2'(t[1] - 1),
              2'(t[0] - 1)};
         s = {11'h0, late, 5'(sd[2]), 5'(sd[1]), 5'(sd[0]), 5'(sw)};
         apb(1'b1, OFS_PHASE_CFG, p, 33'h0);
         apb(1'b1, OFS_STROBE_CFG, s, 33'h0);
         apb(1'b0, OFS_PHASE_CFG, 32'h0, {1'b0, p});
         apb(1'b0, OFS_STROBE_CFG, 32'h0, {1'b0, s});
         wt_en = i % 3 == 0;
         ce_rand <= i % 3 == 1;
         repeat (4) mem_op(2'($urandom % 3), 4'($urandom), 4'(1 + $urandom % 15), $urandom);
         drain;
         ce_rand <= 1'b0;
         wt_en = 1'b0;
         $display("test %0d done", i);
      end
      wrap_up;
   end
endmodule : emsg_strobe_gen_tb
`default_nettype wire
